// ==== logic/hmd_pkg.sv ====
package hmd_pkg;
  localparam int ADDR_W = 32;
  localparam int TOP_W = 32;
  // A/B compatible range
  localparam logic [31:0] A_LO = 32'h000A0000;
  localparam logic [31:0] A_HI = 32'h000BFFFF;
  // High alias range and its translation offset
  localparam logic [31:0] H_LO = 32'h100A0000;
  localparam logic [31:0] H_HI = 32'h100FFFFF;
  localparam logic [31:0] HIGH_BASE = 32'h10000000;
  // Extended space window: 256 MB to 512 MB
  localparam logic [31:0] EXT_LO = 32'h10000000;
  localparam logic [31:0] EXT_HI = 32'h1FFFFFFF;
  // Top segment sizes by size code
  localparam logic [1:0] SZ_128K = 2'h0;
  localparam logic [1:0] SZ_256K = 2'h1;
  localparam logic [1:0] SZ_512K = 2'h2;
  localparam logic [1:0] SZ_1M = 2'h3;
  localparam logic [31:0] BYTES_128K = 32'h00020000;
  localparam logic [31:0] BYTES_256K = 32'h00040000;
  localparam logic [31:0] BYTES_512K = 32'h00080000;
  localparam logic [31:0] BYTES_1M = 32'h00100000;
  localparam logic [31:0] A_SEG_BYTES = 32'h00010000;
  // Routing decision
  typedef enum logic [1:0] {
    HMD_ROUTE_NONE = 2'b00,
    HMD_ROUTE_DRAM = 2'b01,
    HMD_ROUTE_PCI = 2'b10
  } hmd_route_e;
endpackage : hmd_pkg

// ==== logic/hmd_range_chk.sv ====
`timescale 1ns/1ns
// Inclusive range compare
module hmd_range_chk #(
  parameter int W = 32
) (
  input wire logic [W-1:0] addr, // Address under test
  input wire logic [W-1:0] lo, // Lowest address
  input wire logic [W-1:0] hi, // Highest address
  input wire logic en, // Range active
  output logic hit // Address in active range
);
  assign hit = en && (addr >= lo) && (addr <= hi);
endmodule : hmd_range_chk

// ==== logic/hmd_decode.sv ====
`timescale 1ns/1ns
// Function
// [RL1] Top segment size chosen by two-bit code: 128K, 256K, 512K or 1M.
// [RL2] Enabled top segment is removed from ordinary memory below top of memory.
// [RL3] Extended handler space lives between 256 MB and 512 MB.
// [RL4] High range 100A0000h-100FFFFFh translates to DRAM 000A0000h-000FFFFFh.
// [RL5] Top alias 10000000h+top-size..top maps to DRAM top-size..top.
// [RL6] High range DRAM usable only with global and high enable set.
// [RL7] Top segment usable only with segment and global enable set.
// [RL8] Bus-master accesses to extended handler ranges are never claimed.
// [RL9] Non-management access without open goes to PCI and sets status.
// [RL10] Processor reaches handler DRAM in management mode or with open.
// [RL11] Global enable gates all ranges; high and top follow their enables.
// [RL12] A range 0A0000h-0BFFFFh; top range 256M+top-size to 256M+top.
// [RL13] Global enable clear disables code and data to every range.
// [RL14] Unlocked, open set, close clear: DRAM for code and data anywhere.
// [RL15] Lock set ignores open; only management-mode cycles reach DRAM.
// [RL16] Close set in management mode: code to DRAM, data to PCI.
// [RL17] Software must not set close and open together while unlocked.
// [RL18] PCI master hitting handler memory gets no response, no DEVSEL.
// [RL19] A/B access outside management mode without open goes to PCI.
module hmd_decode
  import hmd_pkg::*;
(
  input wire logic ref_clk, // Host clock
  input wire logic rst, // Async reset, active high
  input wire logic clk_en, // Freezes state while low
  input wire logic global_handler_decode_enable, // Global enable
  input wire logic high_range_enable, // High range enable
  input wire logic top_segment_enable, // Top segment enable
  input wire logic [1:0] top_segment_size, // Top segment size code
  input wire logic open_access_bit_alt, // Open access
  input wire logic decode_lock_bit, // Lock
  input wire logic close_data_bit, // Close data
  input wire logic [hmd_pkg::TOP_W-1:0] top_of_installed_memory, // Installed memory top
  input wire logic status_clear, // Clears violation status
  input wire logic cpu_valid, // Processor cycle present
  input wire logic [hmd_pkg::ADDR_W-1:0] cpu_addr, // Processor address
  input wire logic cpu_code, // Cycle is a code fetch
  input wire logic management_mode, // Processor in management mode
  input wire logic pci_valid, // PCI master cycle present
  input wire logic [hmd_pkg::ADDR_W-1:0] pci_addr, // PCI master address
  output logic cpu_to_dram, // Processor cycle served by DRAM
  output logic cpu_to_pci, // Processor cycle forwarded to PCI
  output logic [hmd_pkg::ADDR_W-1:0] dram_addr, // Translated DRAM address
  output logic cpu_done, // Registered decision valid
  output logic pci_claim, // PCI cycle claimed (DEVSEL)
  output logic [hmd_pkg::ADDR_W-1:0] usable_top, // Top of ordinary memory
  output logic violation_status // Sticky outside-mode access status
);
  import hmd_pkg::*;

  logic [31:0] seg_bytes;
  logic [31:0] t_lo;
  logic [31:0] t_hi;
  logic [31:0] ta_lo;
  logic [31:0] ta_hi;
  logic a_en;
  logic h_en;
  logic t_en;
  logic hit_a;
  logic hit_h;
  logic hit_t;
  logic hit_ta;
  logic cpu_hit;
  logic cpu_ext;
  logic pci_hit_ext;
  logic pci_hit_ab;
  logic pci_hit_t;
  logic pci_mem;
  logic allow;
  logic viol;
  logic [31:0] xlat;
  hmd_route_e route;
  logic cpu_to_dram_r;
  logic cpu_to_pci_r;
  logic cpu_done_r;
  logic [31:0] dram_addr_r;
  logic pci_claim_r;
  logic violation_status_r;

  always_comb
  begin
    case (top_segment_size) // [RL1]
      SZ_128K: seg_bytes = BYTES_128K;
      SZ_256K: seg_bytes = BYTES_256K;
      SZ_512K: seg_bytes = BYTES_512K;
      SZ_1M: seg_bytes = BYTES_1M;
      default: seg_bytes = BYTES_128K;
    endcase
  end

  // Range enables
  assign a_en = global_handler_decode_enable; // [RL11] [RL13]
  assign h_en = global_handler_decode_enable && high_range_enable; // [RL6] [RL11]
  assign t_en = global_handler_decode_enable && top_segment_enable; // [RL7] [RL11]

  // Top segment bounds in DRAM and in the 256 MB alias
  assign t_lo = top_of_installed_memory - seg_bytes; // [RL5]
  assign t_hi = top_of_installed_memory - 32'h00000001;
  assign ta_lo = HIGH_BASE + t_lo; // [RL12] [RL3]
  assign ta_hi = HIGH_BASE + t_hi;

  assign usable_top = t_en ? t_lo : top_of_installed_memory; // [RL2]

  hmd_range_chk #(.W(32)) u_a (.addr(cpu_addr), .lo(A_LO), .hi(A_HI), .en(a_en), .hit(hit_a)); // [RL12]
  hmd_range_chk #(.W(32)) u_h (.addr(cpu_addr), .lo(H_LO), .hi(H_HI), .en(h_en), .hit(hit_h)); // [RL4]
  hmd_range_chk #(.W(32)) u_t (.addr(cpu_addr), .lo(ta_lo), .hi(ta_hi), .en(t_en), .hit(hit_ta)); // [RL12]
  hmd_range_chk #(.W(32)) u_td (.addr(pci_addr), .lo(t_lo), .hi(t_hi), .en(t_en), .hit(pci_hit_t));
  hmd_range_chk #(.W(32)) u_pe (.addr(pci_addr), .lo(EXT_LO), .hi(EXT_HI), .en(1'b1), .hit(pci_hit_ext));
  hmd_range_chk #(.W(32)) u_pa (.addr(pci_addr), .lo(A_LO), .hi(A_HI), .en(a_en), .hit(pci_hit_ab));

  assign hit_t = hit_ta;
  assign cpu_hit = hit_a || hit_h || hit_t;
  assign cpu_ext = cpu_addr >= EXT_LO && cpu_addr <= EXT_HI;

  // Access control from lock, open, close and mode
  always_comb
  begin
    allow = 1'b0;
    if (!global_handler_decode_enable)
      allow = 1'b0; // [RL13]
    else if (decode_lock_bit)
      allow = management_mode && !(close_data_bit && !cpu_code); // [RL15] [RL16]
    else if (open_access_bit_alt)
      allow = !close_data_bit; // [RL14] [RL17]
    else if (management_mode)
      allow = !(close_data_bit && !cpu_code); // [RL10] [RL16]
    else
      allow = 1'b0; // [RL19]
  end

  assign viol = cpu_valid && cpu_hit && !management_mode && !open_access_bit_alt; // [RL9]

  // Address translation into DRAM
  always_comb
  begin
    if (hit_h || hit_t)
      xlat = cpu_addr - HIGH_BASE; // [RL4] [RL5]
    else
      xlat = cpu_addr;
  end

  always_comb
  begin
    if (!cpu_valid)
      route = HMD_ROUTE_NONE;
    else if (cpu_hit && allow)
      route = HMD_ROUTE_DRAM; // [RL10]
    else if (cpu_hit)
      route = HMD_ROUTE_PCI; // [RL9] [RL19]
    else if (cpu_ext || cpu_addr >= top_of_installed_memory || (cpu_addr >= A_LO && cpu_addr <= A_HI))
      route = HMD_ROUTE_PCI;
    else if (cpu_addr >= usable_top)
      route = HMD_ROUTE_PCI; // [RL2]
    else
      route = HMD_ROUTE_DRAM;
  end

  // PCI masters may claim ordinary memory only
  assign pci_mem = pci_valid && !pci_hit_ext && !pci_hit_ab && !pci_hit_t
    && pci_addr < top_of_installed_memory; // [RL8] [RL18]

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cpu_to_dram_r <= 1'b0;
      cpu_to_pci_r <= 1'b0;
      cpu_done_r <= 1'b0;
      dram_addr_r <= 32'h00000000;
    end
    else if (clk_en)
    begin
      cpu_to_dram_r <= route == HMD_ROUTE_DRAM;
      cpu_to_pci_r <= route == HMD_ROUTE_PCI;
      cpu_done_r <= cpu_valid;
      dram_addr_r <= xlat;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      pci_claim_r <= 1'b0;
    else if (clk_en)
      pci_claim_r <= pci_mem; // [RL18]
  end

  // Sticky status; a new violation wins over a clear
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      violation_status_r <= 1'b0;
    else if (clk_en)
    begin
      if (viol)
        violation_status_r <= 1'b1; // [RL9]
      else if (status_clear)
        violation_status_r <= 1'b0;
    end
  end

  assign cpu_to_dram = cpu_to_dram_r;
  assign cpu_to_pci = cpu_to_pci_r;
  assign cpu_done = cpu_done_r;
  assign dram_addr = dram_addr_r;
  assign pci_claim = pci_claim_r;
  assign violation_status = violation_status_r;

  lock_mode_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL15]
    clk_en && cpu_valid && decode_lock_bit && !management_mode |=> !cpu_to_dram || !$past(cpu_hit))
    else $error("locked non-management handler access reached DRAM");
  global_off_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL13]
    clk_en && cpu_valid && !global_handler_decode_enable && cpu_ext |=> cpu_to_pci)
    else $error("extended access with global off not forwarded");
  pci_refuse_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL8]
    clk_en && pci_valid && pci_addr >= EXT_LO && pci_addr <= EXT_HI |=> !pci_claim)
    else $error("bus master extended access claimed");
  status_set_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL9]
    clk_en && viol |=> violation_status && cpu_to_pci)
    else $error("violation not flagged or not forwarded");
  close_data_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL16]
    clk_en && cpu_valid && hit_a && management_mode && close_data_bit && !cpu_code |=> cpu_to_pci)
    else $error("close data access not forwarded");
  high_xlat_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL4]
    clk_en && cpu_valid && hit_h && allow |=> cpu_to_dram && dram_addr == $past(cpu_addr) - HIGH_BASE)
    else $error("high range translation wrong");
  open_route_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL14]
    clk_en && cpu_valid && hit_a && !decode_lock_bit && open_access_bit_alt && !close_data_bit
    |=> cpu_to_dram)
    else $error("open access not served from DRAM");
  abseg_pci_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL19]
    clk_en && cpu_valid && cpu_addr >= A_LO && cpu_addr <= A_HI && !management_mode
    && !open_access_bit_alt |=> cpu_to_pci)
    else $error("A/B access outside management mode not forwarded");
  top_hide_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL2]
    usable_top == top_of_installed_memory - (t_en ? BYTES_128K << top_segment_size : 32'h00000000))
    else $error("top segment not withdrawn");
  size_sel_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL1]
    t_en && top_segment_size == SZ_1M |-> usable_top == top_of_installed_memory - BYTES_1M)
    else $error("largest top segment size wrong");

  // Output timing and freeze
  done_follow_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL10]
    clk_en |=> cpu_done == $past(cpu_valid))
    else $error("decision valid does not follow the cycle");
  freeze_hold_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL9]
    !clk_en |=> $stable(cpu_done) && $stable(cpu_to_dram) && $stable(cpu_to_pci) && $stable(dram_addr)
    && $stable(pci_claim) && $stable(violation_status))
    else $error("state moved while clock enable low");
  route_onehot_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL10]
    cpu_done == (cpu_to_dram || cpu_to_pci) && !(cpu_to_dram && cpu_to_pci))
    else $error("routing outputs inconsistent");

  // Range enables and processor routing
  global_gate_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL13]
    clk_en && cpu_valid && !global_handler_decode_enable
    && (cpu_addr >= A_LO && cpu_addr <= A_HI || cpu_addr >= H_LO && cpu_addr <= H_HI) |=> cpu_to_pci)
    else $error("handler range reached DRAM with global off");
  high_off_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL6] [RL11]
    clk_en && cpu_valid && !high_range_enable && cpu_addr >= H_LO && cpu_addr <= H_HI && !hit_t |=> cpu_to_pci)
    else $error("high range served while disabled");
  top_off_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL7] [RL11]
    clk_en && cpu_valid && !top_segment_enable && cpu_addr >= ta_lo && cpu_addr <= ta_hi && !hit_h
    |=> cpu_to_pci)
    else $error("top segment served while disabled");
  top_alias_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL5]
    clk_en && cpu_valid && hit_t && allow |=> cpu_to_dram && dram_addr == $past(cpu_addr) - HIGH_BASE)
    else $error("top alias translation wrong");
  top_carve_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL2]
    clk_en && cpu_valid && t_en && !cpu_hit && cpu_addr >= t_lo && cpu_addr < top_of_installed_memory |=> cpu_to_pci)
    else $error("withdrawn top block served as ordinary memory");
  code_fetch_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL16]
    clk_en && cpu_valid && cpu_hit && management_mode && close_data_bit && cpu_code
    && !(open_access_bit_alt && !decode_lock_bit) |=> cpu_to_dram)
    else $error("management code fetch not served from DRAM");
  mode_dram_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL10] [RL16]
    clk_en && cpu_valid && cpu_hit && management_mode && !close_data_bit |=> cpu_to_dram)
    else $error("management access not served from DRAM");
  lock_open_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL15]
    clk_en && cpu_valid && cpu_hit && decode_lock_bit && open_access_bit_alt
    && !management_mode |=> cpu_to_pci)
    else $error("lock did not override open");
  plain_dram_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL2]
    clk_en && cpu_valid && !cpu_hit && cpu_addr < usable_top && cpu_addr < top_of_installed_memory
    && cpu_addr < EXT_LO && !(cpu_addr >= A_LO && cpu_addr <= A_HI) |=> cpu_to_dram)
    else $error("ordinary memory access not served from DRAM");
  plain_addr_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL4]
    clk_en && cpu_valid && !hit_h && !hit_t |=> dram_addr == $past(cpu_addr))
    else $error("untranslated address altered");

  // Sticky status
  status_hold_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL9]
    clk_en && violation_status && !status_clear |=> violation_status)
    else $error("violation status lost without clear");
  status_clear_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL9]
    clk_en && status_clear && !viol |=> !violation_status)
    else $error("violation status not cleared");

  // Bus master refusal and ordinary memory claim
  pci_ab_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL18]
    clk_en && pci_valid && global_handler_decode_enable && pci_addr >= A_LO && pci_addr <= A_HI |=> !pci_claim)
    else $error("bus master A/B access claimed");
  pci_top_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL8]
    clk_en && pci_valid && t_en && pci_addr >= t_lo && pci_addr <= t_hi |=> !pci_claim)
    else $error("bus master top segment access claimed");
  claim_mem_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL18]
    clk_en && pci_valid && pci_addr < usable_top && pci_addr < top_of_installed_memory && pci_addr < EXT_LO
    && !(global_handler_decode_enable && pci_addr >= A_LO && pci_addr <= A_HI) |=> pci_claim)
    else $error("bus master ordinary access not claimed");
endmodule : hmd_decode

// ==== testbench/hmd_host_model.sv ====
`timescale 1ns/1ns
// Processor and PCI master side of the decoder
module hmd_host_model (
  output logic cpu_valid, // Processor cycle present
  output logic [31:0] cpu_addr, // Processor address
  output logic cpu_code, // Code fetch
  output logic management_mode, // Management mode
  output logic pci_valid, // PCI master cycle present
  output logic [31:0] pci_addr // PCI master address
);
  // Idle buses show the inverse, never a stale address
  task automatic drive(input logic v, input logic [31:0] a, input logic c, input logic m, input logic pv,
                       input logic [31:0] pa);
    cpu_valid = v;
    cpu_addr = v ? a : ~a;
    cpu_code = c;
    management_mode = m;
    pci_valid = pv;
    pci_addr = pv ? pa : ~pa;
  endtask : drive
endmodule : hmd_host_model

// ==== testbench/handler_memory_decode_tb.sv ====
`timescale 1ns/1ns
module handler_memory_decode_tb;
  import hmd_pkg::*;
  logic ref_clk, rst, clk_en, g, h, t, opn, lck, cls, sclr, vi, e_done, e_claim, e_vio, sk_v;
  logic [1:0] tsz, e_r;
  logic [31:0] mem_top, e_da, r, a, ca, pa;
  wire cv, cc, mm, pv, to_dram, to_pci, done, claim, vio;
  wire [31:0] cadr, padr, da, utop;
  int n_fail, num_checks, seed;
  hmd_host_model i_host (.cpu_valid(cv), .cpu_addr(cadr), .cpu_code(cc), .management_mode(mm),
    .pci_valid(pv), .pci_addr(padr));
  hmd_decode i_dut (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .global_handler_decode_enable(g),
    .high_range_enable(h), .top_segment_enable(t), .top_segment_size(tsz), .open_access_bit_alt(opn),
    .decode_lock_bit(lck), .close_data_bit(cls), .top_of_installed_memory(mem_top), .status_clear(sclr),
    .cpu_valid(cv), .cpu_addr(cadr), .cpu_code(cc), .management_mode(mm), .pci_valid(pv), .pci_addr(padr),
    .cpu_to_dram(to_dram), .cpu_to_pci(to_pci), .dram_addr(da), .cpu_done(done), .pci_claim(claim),
    .usable_top(utop), .violation_status(vio));
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  // Range edges, one off either side, up to 4095 past an edge, or a random address below 512 MB
  function automatic logic [31:0] pick(input logic [31:0] x);
    logic [31:0] sz;
    logic [31:0] p [8];
    sz = BYTES_128K << tsz;
    p = '{A_LO, A_HI + 1, H_LO, H_HI + 1, HIGH_BASE + mem_top - sz, HIGH_BASE + mem_top, mem_top - sz, mem_top};
    case (x[5:4])
      2'h0: pick = p[x[2:0]] - 1;
      2'h1: pick = p[x[2:0]];
      2'h2: pick = p[x[2:0]] + {20'h0, x[31:20]};
      default: pick = x & 32'h1FFFFFFF;
    endcase
  endfunction : pick
  function automatic logic [1:0] route(input logic [31:0] x, input logic code, input logic m,
                                       output logic [31:0] tr, output logic v);
    logic [31:0] sz;
    logic ha, hh, ht, ok;
    sz = BYTES_128K << tsz;
    ha = g && x >= A_LO && x <= A_HI;
    hh = g && h && x >= H_LO && x <= H_HI;
    ht = g && t && x >= HIGH_BASE + mem_top - sz && x < HIGH_BASE + mem_top;
    tr = (hh || ht) ? x - HIGH_BASE : x;
    v = (ha || hh || ht) && !m && !opn;
    ok = (!lck && opn) ? !cls : m && (code || !cls);
    if (ha || hh || ht)
      route = ok ? 2'b01 : 2'b10;
    else
      route = (x < mem_top - ((g && t) ? sz : 0) && !(x >= A_LO && x <= A_HI)) ? 2'b01 : 2'b10;
  endfunction : route
  function automatic logic claim_exp(input logic [31:0] x);
    claim_exp = x < mem_top && !(g && x >= A_LO && x <= A_HI) && !(g && t && x >= mem_top - (BYTES_128K << tsz));
  endfunction : claim_exp
  task automatic rand_req();
    r = $random(seed);
    a = $random(seed);
    {g, h, t, opn, lck, cls} = r[5:0];
    g = g | r[6];
    if (!lck && opn && cls) cls = 1'b0;
    mem_top = 32'h02000000 << r[9:8];
    tsz = r[11:10];
    clk_en = r[14:12] != 3'h0;
    ca = pick(a);
    pa = pick(a ^ r);
    i_host.drive(r[15] | r[16], ca, r[18], r[19], r[17], pa);
    if (clk_en)
    begin
      e_done = r[15] | r[16];
      e_r = e_done ? route(ca, r[18], r[19], e_da, vi) : 2'b00;
      e_vio = e_done && vi;
      sk_v = lck && opn;
      e_claim = r[17] && claim_exp(pa);
    end
    #1;
    chk("usable_top", utop, mem_top - ((g && t) ? BYTES_128K << tsz : 32'h0));
  endtask : rand_req
  initial
  begin
    #48000;
    n_fail++;
    summarize();
  end
  initial
  begin
    seed = 32'h5fde;
    rst = 1'b1;
    clk_en = 1'b1;
    sclr = 1'b1;
    {g, h, t, opn, lck, cls} = 6'h00;
    tsz = 2'h0;
    mem_top = 32'h02000000;
    {e_done, e_claim, e_vio, sk_v} = 4'h0;
    e_r = 2'h0;
    i_host.drive(0, 0, 0, 0, 0, 0);
    repeat (5) @(posedge ref_clk);
    #1;
    chk("cpu_done", done, 0);
    chk("pci_claim", claim, 0);
    rst = 1'b0;
    for (int i = 0; i < 3000; i++)
    begin
      rand_req();
      @(posedge ref_clk);
      #1;
      chk("cpu_done", done, e_done);
      chk("cpu_route", {to_pci, to_dram}, e_r);
      if (e_r == 2'b01) chk("dram_addr", da, e_da);
      chk("pci_claim", claim, e_claim);
      if (!sk_v) chk("violation_status", vio, e_vio);
    end
    // Status stays set after the offending cycle until cleared
    sclr = 1'b0;
    clk_en = 1'b1;
    {g, h, t, opn, lck, cls} = 6'h20;
    i_host.drive(1, A_LO, 0, 0, 0, 0);
    @(posedge ref_clk);
    #1;
    i_host.drive(0, 0, 0, 0, 0, 0);
    @(posedge ref_clk);
    #1;
    chk("violation_status", vio, 1);
    sclr = 1'b1;
    @(posedge ref_clk);
    #1;
    chk("violation_status", vio, 0);
    // A new violation wins over a standing clear
    i_host.drive(1, A_LO, 0, 0, 0, 0);
    @(posedge ref_clk);
    #1;
    chk("violation_status", vio, 1);
    chk("cpu_route", {to_pci, to_dram}, 2'b10);
    summarize();
  end
endmodule : handler_memory_decode_tb
